// file: src/qfs_cfg.svh
`ifndef QFS_CFG_SVH
`define QFS_CFG_SVH
// sizes
`define QFS_NUM_Q        32
`define QFS_LAST_WORD    2'h3
// register byte offsets
`define QFS_REG_CFG      8'h00
`define QFS_REG_DEPTH    8'h04
`define QFS_REG_AF_OFF   8'h08
`define QFS_REG_AE_OFF   8'h0c
`define QFS_REG_STATUS   8'h10
`define QFS_REG_EMPTY    8'h14
`define QFS_REG_FULL     8'h18
`define QFS_REG_AE       8'h1c
// cfg register fields
`define QFS_CFG_QCNT_LSB 0
`define QFS_CFG_QCNT_MSB 5
`define QFS_CFG_WID_LSB  8
`define QFS_CFG_WID_MSB  9
`define QFS_CFG_EXP_BIT  12
// status register fields
`define QFS_ST_POLLED    0
`define QFS_ST_OWNED     1
`define QFS_ST_LEADER    2
`define QFS_ST_WORD_LSB  4
// reset values
`define QFS_RST_QCNT     6'h20
`define QFS_RST_DEPTH    16'h0200
`define QFS_RST_AF_OFF   16'h0010
`define QFS_RST_AE_OFF   16'h0010
`endif

// file: src/qfs_pkg.sv
package qfs_pkg;
  typedef enum logic [1:0] {
    QFS_W40_40 = 2'h0,
    QFS_W40_20 = 2'h1,
    QFS_W20_40 = 2'h2,
    QFS_W20_20 = 2'h3
  } qfs_width_type;

  typedef struct packed {
    logic          expand_en;
    qfs_width_type width;
    logic [5:0]    qcount;
    logic [15:0]   depth;
    logic [15:0]   af_off;
    logic [15:0]   ae_off;
  } qfs_cfg_type;

  typedef struct packed {
    logic       en;
    logic [4:0] queue;
  } qfs_access_type;

  typedef enum logic {
    QFS_WAIT = 1'b0,
    QFS_OWN  = 1'b1
  } qfs_poll_state_type;
endpackage : qfs_pkg

// file: src/qfs_queue_flags.sv
`timescale 1ns/1ps
`include "qfs_cfg.svh"
module qfs_queue_flags (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // configuration and accesses
  input  wire qfs_pkg::qfs_cfg_type cfg,
  input  wire logic                wr_hit,
  input  wire logic                rd_hit,
  // flags, all active low
  output logic                     full_n,
  output logic                     empty_n,
  output logic                     af_flag_n,
  output logic                     af_bus_n,
  output logic                     ae_flag_n
);
  import qfs_pkg::*;

  logic [17:0] cnt_q;
  logic [17:0] cnt_d;
  logic [17:0] in_u;
  logic [17:0] out_u;
  logic [17:0] cap;
  logic [17:0] af_thr;
  logic [17:0] ae_thr;
  logic [15:0] af_words;
  logic [16:0] ae_words;
  logic        wr_ok;
  logic        rd_ok;
  logic        af_lvl_q;
  logic        ae_lvl_q;
  logic [1:0]  af_hist_q;
  logic [1:0]  ae_hist_q;

  // counting in narrow units keeps every width combination on one counter
  always_comb
  begin
    in_u     = (cfg.width == QFS_W20_40 || cfg.width == QFS_W20_20) ? 18'h1 : 18'h2;
    out_u    = (cfg.width == QFS_W40_20 || cfg.width == QFS_W20_20) ? 18'h1 : 18'h2;
    af_words = cfg.depth - cfg.af_off;
    ae_words = {1'b0, cfg.ae_off} + 17'h1;
    if (cfg.width == QFS_W20_20)
    begin
      cap    = {2'h0, cfg.depth};
      af_thr = {2'h0, af_words};
      ae_thr = {1'b0, ae_words};
    end
    else
    begin
      cap    = {1'b0, cfg.depth, 1'b0};
      af_thr = {1'b0, af_words, 1'b0};
      ae_thr = {ae_words, 1'b0};
    end
    wr_ok = wr_hit && (cnt_q + in_u <= cap);
    rd_ok = rd_hit && (cnt_q >= out_u);
    cnt_d = cnt_q + (wr_ok ? in_u : 18'h0) - (rd_ok ? out_u : 18'h0);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q   <= 18'h0;
      full_n  <= 1'b1;
      empty_n <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      full_n  <= !(cnt_d + in_u > cap);
      empty_n <= (cnt_d != 18'h0);
    end
  end

  // levels register once, then age; deassert follows the level one edge later
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      af_lvl_q  <= 1'b0;
      ae_lvl_q  <= 1'b1;
      af_hist_q <= 2'h0;
      ae_hist_q <= 2'h3;
      af_flag_n <= 1'b1;
      af_bus_n  <= 1'b1;
      ae_flag_n <= 1'b0;
    end
    else
    begin
      af_lvl_q  <= (cnt_d >= af_thr);
      ae_lvl_q  <= (cnt_d < ae_thr);
      af_hist_q <= {af_hist_q[0], af_lvl_q};
      ae_hist_q <= {ae_hist_q[0], ae_lvl_q};
      af_flag_n <= !(af_lvl_q && af_hist_q[1]);
      af_bus_n  <= !(af_lvl_q && af_hist_q[0]);
      ae_flag_n <= !(ae_lvl_q && ae_hist_q[1]);
    end
  end

  property p_full_same;
    @(posedge clk_sys) disable iff (!rst_b) (cnt_d + in_u > cap) |=> !full_n;
  endproperty
  a_full_same: assert property (p_full_same) else $error("full flag late");

  property p_af_rise;
    @(posedge clk_sys) disable iff (!rst_b) !af_lvl_q ##1 af_lvl_q [*3] |=> !af_flag_n;
  endproperty
  a_af_rise: assert property (p_af_rise) else $error("almost full flag not after three cycles");

  property p_af_bus;
    @(posedge clk_sys) disable iff (!rst_b) !af_lvl_q ##1 af_lvl_q [*2] |-> af_bus_n ##1 !af_bus_n;
  endproperty
  a_af_bus: assert property (p_af_bus) else $error("almost full bus bit timing wrong");

  property p_ae_clear;
    @(posedge clk_sys) disable iff (!rst_b) $fell(ae_lvl_q) |=> ae_flag_n;
  endproperty
  a_ae_clear: assert property (p_ae_clear) else $error("almost empty flag not released");
endmodule : qfs_queue_flags

// file: src/qfs_status_bus.sv
`timescale 1ns/1ps
`include "qfs_cfg.svh"
module qfs_status_bus (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  // write port controller
  input  wire logic [7:0] write_queue_address,
  input  wire logic       wr_queue_sel,
  input  wire logic       wr_en,
  // read port controller
  input  wire logic [7:0] read_queue_address,
  input  wire logic       rd_queue_sel,
  input  wire logic       rd_en,
  input  wire logic       empty_status_strobe,
  // straps and expansion pins
  input  wire logic       flag_bus_mode_select,
  input  wire logic       bus_leader_select,
  input  wire logic [2:0] device_id_pins,
  input  wire logic       empty_bus_token_in,
  output logic            empty_bus_token_out,
  // almost-empty status bus, three-state
  output logic [7:0]      almost_empty_status_bus,
  output logic            almost_empty_status_bus_oe,
  output logic            empty_bus_sync,
  // discrete flags of the selected queues; almost-full bus for the write queue's group of eight
  output logic            empty_flag_n,
  output logic            full_flag_n,
  output logic            almost_full_flag_n,
  output logic            almost_empty_flag_n,
  output logic [7:0]      almost_full_status_bus
);
  import qfs_pkg::*;

  qfs_cfg_type        cfg_q;
  qfs_access_type     wr_acc;
  qfs_access_type     rd_acc;
  qfs_poll_state_type state_q;
  logic [4:0]  wq_q;
  logic [4:0]  rq_q;
  logic [31:0] hit_wr;
  logic [31:0] hit_rd;
  logic [31:0] full_v;
  logic [31:0] empty_v;
  logic [31:0] af_v;
  logic [31:0] afb_v;
  logic [31:0] ae_v;
  logic        mode_s1;
  logic        mode_s2;
  logic        lead_s1;
  logic        lead_s2;
  logic        tok_s1;
  logic        tok_s2;
  logic [2:0]  id_s1;
  logic [2:0]  id_s2;
  logic        started_q;
  logic        polled_q;
  logic        leader_q;
  logic        polled_now;
  logic        leader_now;
  logic [1:0]  dword_q;
  logic        downer_q;
  logic [1:0]  pword_q;
  logic [1:0]  show_word;
  logic        own_d;
  logic        sync_d;
  logic        take_tok;
  logic        few_q;

  // pin synchronisers, no reset so straps settle while reset is held
  always_ff @(posedge clk_sys)
  begin
    mode_s1 <= flag_bus_mode_select;
    mode_s2 <= mode_s1;
    lead_s1 <= bus_leader_select;
    lead_s2 <= lead_s1;
    tok_s1  <= empty_bus_token_in;
    tok_s2  <= tok_s1;
    id_s1   <= device_id_pins;
    id_s2   <= id_s1;
  end

  // straps caught at the first edge after release
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      started_q <= 1'b0;
      polled_q  <= 1'b0;
      leader_q  <= 1'b0;
    end
    else if (!started_q)
    begin
      started_q <= 1'b1;
      polled_q  <= mode_s2;
      leader_q  <= lead_s2 && (id_s2 == 3'h0);
    end
  end

  assign polled_now = started_q ? polled_q : mode_s2;
  assign leader_now = started_q ? leader_q : (lead_s2 && (id_s2 == 3'h0));
  assign few_q      = (cfg_q.qcount <= 6'h08);

  // register writes
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q.expand_en <= 1'b0;
      cfg_q.width     <= QFS_W40_40;
      cfg_q.qcount    <= `QFS_RST_QCNT;
      cfg_q.depth     <= `QFS_RST_DEPTH;
      cfg_q.af_off    <= `QFS_RST_AF_OFF;
      cfg_q.ae_off    <= `QFS_RST_AE_OFF;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `QFS_REG_CFG:
        begin
          cfg_q.qcount    <= reg_wdata[`QFS_CFG_QCNT_MSB:`QFS_CFG_QCNT_LSB];
          cfg_q.width     <= qfs_width_type'(reg_wdata[`QFS_CFG_WID_MSB:`QFS_CFG_WID_LSB]);
          cfg_q.expand_en <= reg_wdata[`QFS_CFG_EXP_BIT];
        end
        `QFS_REG_DEPTH:  cfg_q.depth  <= reg_wdata[15:0];
        `QFS_REG_AF_OFF: cfg_q.af_off <= reg_wdata[15:0];
        `QFS_REG_AE_OFF: cfg_q.ae_off <= reg_wdata[15:0];
        default:         cfg_q.depth  <= cfg_q.depth;
      endcase
    end
  end

  // register reads, data in the following cycle only
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      case (reg_addr)
        `QFS_REG_CFG:    reg_rdata <= {19'h0, cfg_q.expand_en, 2'h0, cfg_q.width, 2'h0, cfg_q.qcount};
        `QFS_REG_DEPTH:  reg_rdata <= {16'h0, cfg_q.depth};
        `QFS_REG_AF_OFF: reg_rdata <= {16'h0, cfg_q.af_off};
        `QFS_REG_AE_OFF: reg_rdata <= {16'h0, cfg_q.ae_off};
        `QFS_REG_STATUS: reg_rdata <= {26'h0, almost_empty_status_bus_oe ? show_word : 2'h0, 1'b0,
                                       leader_q, almost_empty_status_bus_oe, polled_q};
        `QFS_REG_EMPTY:  reg_rdata <= empty_v;
        `QFS_REG_FULL:   reg_rdata <= full_v;
        `QFS_REG_AE:     reg_rdata <= ae_v;
        default:         reg_rdata <= 32'h0;
      endcase
    end
  end

  // queue selection takes effect from the next cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wq_q <= 5'h0;
      rq_q <= 5'h0;
    end
    else
    begin
      if (wr_queue_sel)
        wq_q <= write_queue_address[4:0];
      if (rd_queue_sel)
        rq_q <= read_queue_address[4:0];
    end
  end

  assign wr_acc = '{en: wr_en, queue: wq_q};
  assign rd_acc = '{en: rd_en, queue: rq_q};

  generate
    for (genvar gi = 0; gi < `QFS_NUM_Q; gi++)
    begin : g_queue
      assign hit_wr[gi] = wr_acc.en && (wr_acc.queue == 5'(gi));
      assign hit_rd[gi] = rd_acc.en && (rd_acc.queue == 5'(gi));
      qfs_queue_flags u_flags (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .cfg       (cfg_q),
        .wr_hit    (hit_wr[gi]),
        .rd_hit    (hit_rd[gi]),
        .full_n    (full_v[gi]),
        .empty_n   (empty_v[gi]),
        .af_flag_n (af_v[gi]),
        .af_bus_n  (afb_v[gi]),
        .ae_flag_n (ae_v[gi])
      );
    end
  endgenerate

  assign full_flag_n            = full_v[wq_q];
  assign almost_full_flag_n     = af_v[wq_q];
  assign empty_flag_n           = empty_v[rq_q];
  assign almost_empty_flag_n    = ae_v[rq_q];
  assign almost_full_status_bus = afb_v[{wq_q[4:3], 3'h0} +: 8];

  // addressed selection; a queue select in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dword_q  <= 2'h0;
      downer_q <= 1'b0;
    end
    else if (empty_status_strobe && !rd_queue_sel)
    begin
      dword_q  <= read_queue_address[1:0];
      downer_q <= !cfg_q.expand_en || (read_queue_address[7:5] == id_s2);
    end
  end

  // token: synced pulse from the previous device in the ring
  assign take_tok = started_q ? tok_s2 : leader_now;

  always_comb
  begin
    own_d     = 1'b0;
    sync_d    = 1'b0;
    show_word = 2'h0;
    if (polled_now)
    begin
      if (state_q == QFS_WAIT)
      begin
        own_d  = take_tok;
        sync_d = take_tok;
      end
      else if (pword_q != `QFS_LAST_WORD)
      begin
        own_d     = 1'b1;
        show_word = pword_q + 2'h1;
      end
    end
    else if (few_q)
      own_d = 1'b1;
    else
    begin
      own_d     = downer_q;
      show_word = dword_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q             <= QFS_WAIT;
      pword_q             <= 2'h0;
      empty_bus_token_out <= 1'b0;
    end
    else
    begin
      state_q             <= own_d && polled_now ? QFS_OWN : QFS_WAIT;
      pword_q             <= show_word;
      empty_bus_token_out <= polled_now && (state_q == QFS_OWN) && !own_d;
    end
  end

  // status refreshed every cycle; late flags show through on the next refresh
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      almost_empty_status_bus    <= 8'hff;
      almost_empty_status_bus_oe <= 1'b0;
      empty_bus_sync             <= 1'b0;
    end
    else
    begin
      almost_empty_status_bus    <= ae_v[{show_word, 3'h0} +: 8];
      almost_empty_status_bus_oe <= own_d;
      empty_bus_sync             <= sync_d;
    end
  end

  property p_direct_lat;
    @(posedge clk_sys) disable iff (!rst_b)
      started_q && !polled_q && !few_q && empty_status_strobe && !rd_queue_sel && !cfg_q.expand_en
      ##1 !empty_status_strobe |=> almost_empty_status_bus_oe && show_word == $past(read_queue_address[1:0], 2);
  endproperty
  a_direct_lat: assert property (p_direct_lat) else $error("selected word not shown");

  property p_few;
    @(posedge clk_sys) disable iff (!rst_b) started_q && !polled_q && few_q |=> almost_empty_status_bus_oe;
  endproperty
  a_few: assert property (p_few) else $error("word zero not driven");

  property p_sync_word;
    @(posedge clk_sys) disable iff (!rst_b)
      polled_q && started_q && sync_d |=> empty_bus_sync ##1 !empty_bus_sync [*3] ##1 empty_bus_token_out;
  endproperty
  a_sync_word: assert property (p_sync_word) else $error("polled sequence wrong");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_b) empty_bus_token_out |-> !almost_empty_status_bus_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus kept after token");

  property p_id_mismatch;
    @(posedge clk_sys) disable iff (!rst_b)
      started_q && !polled_q && !few_q && cfg_q.expand_en && empty_status_strobe && !rd_queue_sel
      && read_queue_address[7:5] != id_s2 |=> ##1 !almost_empty_status_bus_oe;
  endproperty
  a_id_mismatch: assert property (p_id_mismatch) else $error("foreign selection answered");

  c_direct: cover property (@(posedge clk_sys) disable iff (!rst_b) !polled_q && empty_status_strobe);
  c_polled: cover property (@(posedge clk_sys) disable iff (!rst_b) empty_bus_token_out);
  c_full:   cover property (@(posedge clk_sys) disable iff (!rst_b) !full_flag_n);
endmodule : qfs_status_bus

// file: verif/qfs_rd_ctrl.sv
`timescale 1ns/1ps
module qfs_rd_ctrl #(
  parameter logic [2:0] DEV_NUM = 3'h0
) (
  // clock
  input  wire logic  clk_sys,
  // read port drive
  output logic [7:0] read_queue_address,
  output logic       rd_queue_sel,
  output logic       rd_en,
  output logic       empty_status_strobe
);
  initial
  begin
    read_queue_address  = 8'h00;
    rd_queue_sel        = 1'h0;
    rd_en               = 1'h0;
    empty_status_strobe = 1'h0;
  end

  // word number low, device number high; queue select kept apart
  task automatic pick(input logic [1:0] w);
    @(posedge clk_sys);
    rd_queue_sel        <= 1'h0;
    empty_status_strobe <= 1'h1;
    read_queue_address  <= {DEV_NUM, 3'h0, w};
  endtask : pick

  // queue latched first, reads start on the edge after the latching edge
  task automatic read_from(input logic [4:0] q, input int n);
    @(posedge clk_sys);
    empty_status_strobe <= 1'h0;
    rd_queue_sel        <= 1'h1;
    read_queue_address  <= {3'h0, q};
    @(posedge clk_sys);
    rd_queue_sel <= 1'h0;
    rd_en        <= 1'h1;
    repeat (n) @(posedge clk_sys);
    rd_en <= 1'h0;
  endtask : read_from

  // address scrambled off strobe so a stale value cannot be relied on
  task automatic idle();
    @(posedge clk_sys);
    empty_status_strobe <= 1'h0;
    read_queue_address  <= ~read_queue_address;
  endtask : idle
endmodule : qfs_rd_ctrl

// file: verif/qfs_status_bus_tb.sv
`timescale 1ns/1ps
module qfs_status_bus_tb;
  import qfs_pkg::*;
  typedef struct packed {
    logic        is_word;
    logic [7:0]  addr;
    logic [31:0] exp;
  } qfs_tb_row_type;

  logic           clk_sys    = 1'h0;
  logic           rst_b      = 1'h0;
  logic [7:0]     reg_addr   = 8'h00;
  logic [31:0]    reg_wdata  = 32'h0;
  logic           reg_wr     = 1'h0;
  logic           reg_rd     = 1'h0;
  logic [7:0]     wq_addr    = 8'h00;
  logic           wq_sel     = 1'h0;
  logic           wr_en      = 1'h0;
  logic           mode_sel   = 1'h0;
  logic           leader_sel = 1'h0;
  logic [2:0]     dev_id     = 3'h0;
  logic [31:0]    reg_rdata;
  logic [31:0]    rd;
  logic [7:0]     rq_addr;
  logic           rq_sel;
  logic           rd_en;
  logic           strobe;
  logic           tok;
  logic [7:0]     ae_bus;
  logic           ae_oe;
  logic           sync;
  logic           ef_n;
  logic           ff_n;
  logic           af_n;
  logic           ae_n;
  logic [7:0]     af_bus;
  logic           seen;
  int             miscompares = 0;
  int             num_checks  = 0;
  qfs_tb_row_type rows [13];

  always #12.5 clk_sys = ~clk_sys;

  qfs_rd_ctrl u_ctrl (
    .clk_sys             (clk_sys),
    .read_queue_address  (rq_addr),
    .rd_queue_sel        (rq_sel),
    .rd_en               (rd_en),
    .empty_status_strobe (strobe)
  );

  // lone device: token output loops straight back
  qfs_status_bus u_dut (
    .clk_sys                    (clk_sys),
    .rst_b                      (rst_b),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_wr                     (reg_wr),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .write_queue_address        (wq_addr),
    .wr_queue_sel               (wq_sel),
    .wr_en                      (wr_en),
    .read_queue_address         (rq_addr),
    .rd_queue_sel               (rq_sel),
    .rd_en                      (rd_en),
    .empty_status_strobe        (strobe),
    .flag_bus_mode_select       (mode_sel),
    .bus_leader_select          (leader_sel),
    .device_id_pins             (dev_id),
    .empty_bus_token_in         (tok),
    .empty_bus_token_out        (tok),
    .almost_empty_status_bus    (ae_bus),
    .almost_empty_status_bus_oe (ae_oe),
    .empty_bus_sync             (sync),
    .empty_flag_n               (ef_n),
    .full_flag_n                (ff_n),
    .almost_full_flag_n         (af_n),
    .almost_empty_flag_n        (ae_n),
    .almost_full_status_bus     (af_bus)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1 d = reg_rdata;
  endtask : reg_read

  // word taken one edge after the strobe goes up, shown one edge later
  task automatic word_check(input logic [1:0] w, input logic [7:0] exp);
    u_ctrl.pick(w);
    u_ctrl.idle();
    @(posedge clk_sys);
    #1 check({ae_oe, ae_bus}, {1'h1, exp});
  endtask : word_check

  task automatic wr_queue(input logic [4:0] q);
    @(posedge clk_sys);
    wq_sel  <= 1'h1;
    wq_addr <= {3'h0, q};
    @(posedge clk_sys);
    wq_sel  <= 1'h0;
  endtask : wr_queue

  task automatic wr_burst(input int n);
    @(posedge clk_sys);
    wr_en <= 1'h1;
    repeat (n) @(posedge clk_sys);
    wr_en <= 1'h0;
    #1;
  endtask : wr_burst

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end

  initial
  begin
    rows = '{'{1'h0, 8'h00, 32'h20}, '{1'h0, 8'h04, 32'h200}, '{1'h0, 8'h08, 32'h10},
             '{1'h0, 8'h0c, 32'h10}, '{1'h0, 8'h40, 32'h0}, '{1'h0, 8'h10, 32'h0}, '{1'h0, 8'h14, 32'h0},
             '{1'h0, 8'h18, 32'hffffffff}, '{1'h0, 8'h1c, 32'h0}, '{1'h1, 8'h00, 32'h0},
             '{1'h1, 8'h01, 32'h0}, '{1'h1, 8'h02, 32'h0}, '{1'h1, 8'h03, 32'h0}};
    repeat (4) @(posedge clk_sys);
    #1 check({ae_bus, ae_oe, sync, tok, ef_n, ff_n, af_n, ae_n}, 32'h7f86);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'h1;
    $display("reset test done");
    foreach (rows[i])
    begin
      if (rows[i].is_word)
        word_check(rows[i].addr[1:0], rows[i].exp[7:0]);
      else
      begin
        reg_read(rows[i].addr, rd);
        check(rd, rows[i].exp);
      end
    end
    $display("table test done");
    // almost-empty boundary at n+1 writes, queue 9 is word 1 bit 1
    reg_write(8'h0c, 32'h2);
    wr_queue(5'h09);
    wr_burst(2);
    reg_read(8'h14, rd);
    check(rd, 32'h200);
    repeat (6) @(posedge clk_sys);
    word_check(2'h1, 8'h00);
    wr_burst(1);
    repeat (6) @(posedge clk_sys);
    word_check(2'h1, 8'h02);
    $display("almost empty test done");
    // selections on consecutive edges
    u_ctrl.pick(2'h1);
    u_ctrl.pick(2'h0);
    u_ctrl.idle();
    #1 check(ae_bus, 8'h02);
    @(posedge clk_sys);
    #1 check(ae_bus, 8'h00);
    $display("back to back test done");
    // depth 4, almost-full offset 1: flag set after 3 writes, full after 4
    reg_write(8'h04, 32'h4);
    reg_write(8'h08, 32'h1);
    wr_queue(5'h02);
    wr_burst(2);
    repeat (6) @(posedge clk_sys);
    #1 check({af_n, af_bus, ff_n}, {1'h1, 8'hff, 1'h1});
    wr_burst(1);
    check(ff_n, 1'h1);
    @(posedge clk_sys);
    #1 check({af_n, af_bus}, {1'h1, 8'hff});
    repeat (3) @(posedge clk_sys);
    #1 check({af_n, af_bus}, {1'h0, 8'hfb});
    wr_burst(1);
    check(ff_n, 1'h0);
    $display("full test done");
    // expansion on: a foreign device number leaves the bus alone
    reg_write(8'h00, 32'h1020);
    dev_id <= 3'h5;
    repeat (2) @(posedge clk_sys);
    u_ctrl.pick(2'h0);
    u_ctrl.idle();
    @(posedge clk_sys);
    #1 check(ae_oe, 1'h0);
    dev_id <= 3'h0;
    repeat (2) @(posedge clk_sys);
    word_check(2'h0, 8'h04);
    // eight queues: word zero whatever is selected
    reg_write(8'h00, 32'h8);
    word_check(2'h3, 8'h04);
    $display("expansion test done");
    // reads from queue 9, three words held
    u_ctrl.read_from(5'h09, 1);
    #1 check(ef_n, 1'h1);
    repeat (2) @(posedge clk_sys);
    #1 check(ae_n, 1'h1);
    @(posedge clk_sys);
    #1 check(ae_n, 1'h0);
    u_ctrl.read_from(5'h09, 2);
    #1 check({ef_n, ae_n}, 2'h0);
    $display("read test done");
    // polled leader after a second reset
    @(posedge clk_sys);
    rst_b      <= 1'h0;
    mode_sel   <= 1'h1;
    leader_sel <= 1'h1;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'h1;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_sys);
      #1 check({ae_oe, sync, tok}, {k < 4, k == 0, k == 4});
      if (k < 4)
        check(ae_bus, 8'h00);
    end
    seen = 1'h0;
    for (int k = 0; k < 12 && !seen; k++)
    begin
      @(posedge clk_sys);
      #1 seen = (sync === 1'h1);
    end
    check(seen, 1'h1);
    repeat (4) @(posedge clk_sys);
    #1 check({ae_oe, tok}, 2'h1);
    repeat (2) @(posedge clk_sys);
    $display("polled test done");
    conclude();
  end
endmodule : qfs_status_bus_tb
